// [ddmux_consts.svh]
// Constants for the diagnostic digital multiplexer, groups 2 to 4
`ifndef DDMUX_CONSTS_SVH
`define DDMUX_CONSTS_SVH

`define DDMUX_CFG_DIGITAL 2'h1
`define DDMUX_GRP_TIMING 3'h1
`define DDMUX_GRP_PUMP 3'h2
`define DDMUX_GRP_SUPPLY 3'h3
`define DDMUX_CH_SYSCLK 4'h1
`define DDMUX_CH_TEST2 4'h2
`define DDMUX_CH_WDCLK 4'h3
`define DDMUX_CH_RSTOSC 4'h4
`define DDMUX_CH_T5US 4'h5
`define DDMUX_CH_T15US 4'h6
`define DDMUX_CH_T40US 4'h7
`define DDMUX_CH_T2MS 4'h8
`define DDMUX_CH_ERRIN 4'h9
`define DDMUX_CH_NCS 4'ha
`define DDMUX_CH_SDI 4'hb
`define DDMUX_CH_SCLK 4'hc
`define DDMUX_CH_SDORB 4'hd
`define DDMUX_CH_ERRIN2 4'he
`define DDMUX_CH_NRESRB 4'hf
`define DDMUX_CH_TEST1 4'h1
`define DDMUX_CH_CPOV 4'h3
`define DDMUX_CH_CPUV 4'h4
`define DDMUX_CH_CPPH1 4'h5
`define DDMUX_CH_CPPH2 4'h6
`define DDMUX_CH_CPDIFF 4'h7
`define DDMUX_CH_TEST8 4'h8
`define DDMUX_CH_BATUV 4'h9
`define DDMUX_CH_BATOV 4'ha
`define DDMUX_CH_V5OT 4'hb
`define DDMUX_CH_V35OT 4'hc
`define DDMUX_CH_VSOT 4'hd
`define DDMUX_CH_V5CL 4'he
`define DDMUX_CH_V3CL 4'hf
`define DDMUX_CH_VSCL 4'h1
`define DDMUX_CH_VSUV 4'h2
`define DDMUX_CH_VSOV 4'h3
`define DDMUX_CH_DUV 4'h4
`define DDMUX_CH_DOV 4'h5
`define DDMUX_CH_TRK 4'h7
`define DDMUX_CH_TRIM 4'h8
`define DDMUX_WDCLK_PERIOD_NS 550000
`define DDMUX_CLK_PERIOD_NS 40

`endif

// [ddmux_pkg.sv]
// Types for the diagnostic digital multiplexer
package ddmux_pkg;
  typedef logic [2:0] ddmux_group_type;
  typedef logic [3:0] ddmux_chan_type;
  typedef logic [1:0] ddmux_cfg_type;
endpackage : ddmux_pkg

// [ddmux_sync_if.sv]
// Carrier between the top and its pin synchroniser
interface ddmux_sync_if;
  logic [27:0] raw;
  logic [27:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : ddmux_sync_if

// [ddmux_sync.sv]
// Two-stage synchroniser for 28 sampled diagnostic sources; the other four taps are synchronised in the top
module ddmux_sync (
  input wire logic mclk_i,
  input wire logic rst_i,
  ddmux_sync_if.sync port_s
);
  logic [27:0] stage_a;
  logic [27:0] stage_b;
  assign port_s.clean = stage_b;
  // First stage is read by the second stage only
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stage_a <= 28'h000_0000;
      stage_b <= 28'h000_0000;
    end else begin
      stage_a <= port_s.raw;
      stage_b <= stage_a;
    end
  end
endmodule : ddmux_sync

// [ddmux_top.sv]
// Diagnostic digital multiplexer, channel groups 2 to 4
// How it works
// - Group 001b channel 0011b outputs the 0.55 ms watchdog time base
// - Group 001b channel 0100b outputs the reset stretch oscillator
// - Group 001b channel 1001b or 1110b mirrors the host error trigger input
// - Group 001b channel 1010b reflects the serial select input
// - Group 001b channel 1011b reflects the serial data input
// - Group 001b channel 1101b outputs the serial output pin readback
// - Channel 1110b equals channel 1001b in group 001b
// - Group 001b channel 1111b outputs the host reset pin readback
// - Production test codes carry no user function
// - Group 010b: 0100b inverted pump under, 0011b pump over
// - Group 010b: 0101b pump phase one, 0110b pump phase two
// - Group 010b channel 0111b shows pump above battery by 3 V
// - Group 010b: 1001b inverted battery under, 1010b battery over
// - Group 011b: 0001b supply limit, 0010b inverted under, 0011b over
// - Group 011b: 0100b inverted digital under, 0101b digital over
// - Group 011b: 0111b tracking indication, 1000b monitor trim fault
`include "ddmux_consts.svh"
module ddmux_top #(
  parameter int WD_HALF_CYCLES = `DDMUX_WDCLK_PERIOD_NS / `DDMUX_CLK_PERIOD_NS / 2
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire ddmux_pkg::ddmux_cfg_type mux_mode_config_i,
  input wire ddmux_pkg::ddmux_group_type diag_group_i,
  input wire ddmux_pkg::ddmux_chan_type diag_channel_i,
  input wire logic system_clock_tap_i,
  input wire logic production_test_signal_i,
  input wire logic reset_stretch_oscillator_i,
  input wire logic time_5us_i,
  input wire logic time_15us_i,
  input wire logic time_40us_i,
  input wire logic time_2ms_i,
  input wire logic host_error_trigger_input_i,
  input wire logic serial_select_tap_i,
  input wire logic serial_in_tap_i,
  input wire logic serial_clock_tap_i,
  input wire logic serial_out_readback_i,
  input wire logic host_reset_readback_i,
  input wire logic pump_under_flag_n_i,
  input wire logic pump_over_flag_i,
  input wire logic pump_phase_one_i,
  input wire logic pump_phase_two_i,
  input wire logic pump_headroom_flag_i,
  input wire logic battery_under_flag_n_i,
  input wire logic battery_over_flag_i,
  input wire logic vdd5_overtemp_i,
  input wire logic vdd35_overtemp_i,
  input wire logic sensor_overtemp_i,
  input wire logic vdd5_limit_i,
  input wire logic vdd3_limit_i,
  input wire logic sensor_supply_limit_flag_i,
  input wire logic sensor_supply_under_n_i,
  input wire logic sensor_supply_over_flag_i,
  input wire logic digital_supply_under_n_i,
  input wire logic digital_supply_over_flag_i,
  input wire logic sensor_tracking_indication_i,
  input wire logic monitor_trim_fault_i,
  output logic diagnostic_output_pin_o,
  output logic watchdog_time_base_o
);
  import ddmux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised sources; watchdog base is local so needs no crossing
  ddmux_sync_if sif ();
  logic [27:0] s;

  assign sif.raw = {monitor_trim_fault_i, sensor_tracking_indication_i, digital_supply_over_flag_i,
                    digital_supply_under_n_i, sensor_supply_over_flag_i, sensor_supply_under_n_i,
                    sensor_supply_limit_flag_i, vdd3_limit_i, vdd5_limit_i, sensor_overtemp_i,
                    vdd35_overtemp_i, vdd5_overtemp_i, battery_over_flag_i, battery_under_flag_n_i,
                    pump_headroom_flag_i, pump_phase_two_i, pump_phase_one_i, pump_over_flag_i,
                    pump_under_flag_n_i, host_reset_readback_i, serial_out_readback_i,
                    serial_clock_tap_i, serial_in_tap_i, serial_select_tap_i,
                    host_error_trigger_input_i, time_2ms_i, time_40us_i, time_15us_i};
  assign s = sif.clean;

  ddmux_sync u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .port_s(sif.sync)
  );

  // Remaining fast taps synchronised here, kept apart to stay in 28 bits
  logic [3:0] tap_a;
  logic [3:0] tap_b;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tap_a <= 4'h0;
      tap_b <= 4'h0;
    end else begin
      tap_a <= {system_clock_tap_i, reset_stretch_oscillator_i, time_5us_i, production_test_signal_i};
      tap_b <= tap_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog time base: 0.55 ms period from the master clock
  localparam int WD_W = $clog2(WD_HALF_CYCLES + 1);
  logic [WD_W-1:0] wd_count;
  logic wd_phase;
  wire wd_wrap = (wd_count == WD_W'(WD_HALF_CYCLES - 1));
  wire [WD_W-1:0] next_wd_count = wd_wrap ? '0 : wd_count + WD_W'(1);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wd_count <= '0;
      wd_phase <= 1'b0;
    end else begin
      wd_count <= next_wd_count;
      wd_phase <= wd_phase ^ wd_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection decode
  wire digital_mode = (mux_mode_config_i == `DDMUX_CFG_DIGITAL);
  wire sel_timing = (diag_group_i == `DDMUX_GRP_TIMING);
  wire sel_pump = (diag_group_i == `DDMUX_GRP_PUMP);
  wire sel_supply = (diag_group_i == `DDMUX_GRP_SUPPLY);

  logic timing_bit;
  logic pump_bit;
  logic supply_bit;

  // Test codes read as zero so no user sees internal test state
  always_comb begin
    case (diag_channel_i)
      `DDMUX_CH_SYSCLK: timing_bit = tap_b[3];
      `DDMUX_CH_TEST2: timing_bit = 1'b0;
      `DDMUX_CH_WDCLK: timing_bit = wd_phase;
      `DDMUX_CH_RSTOSC: timing_bit = tap_b[2];
      `DDMUX_CH_T5US: timing_bit = tap_b[1];
      `DDMUX_CH_T15US: timing_bit = s[0];
      `DDMUX_CH_T40US: timing_bit = s[1];
      `DDMUX_CH_T2MS: timing_bit = s[2];
      `DDMUX_CH_ERRIN: timing_bit = s[3];
      `DDMUX_CH_NCS: timing_bit = s[4];
      `DDMUX_CH_SDI: timing_bit = s[5];
      `DDMUX_CH_SCLK: timing_bit = s[6];
      `DDMUX_CH_SDORB: timing_bit = s[7];
      `DDMUX_CH_ERRIN2: timing_bit = s[3];
      `DDMUX_CH_NRESRB: timing_bit = s[8];
      default: timing_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (diag_channel_i)
      `DDMUX_CH_TEST1: pump_bit = 1'b0;
      `DDMUX_CH_TEST2: pump_bit = 1'b0;
      `DDMUX_CH_CPOV: pump_bit = s[10];
      `DDMUX_CH_CPUV: pump_bit = s[9];
      `DDMUX_CH_CPPH1: pump_bit = s[11];
      `DDMUX_CH_CPPH2: pump_bit = s[12];
      `DDMUX_CH_CPDIFF: pump_bit = s[13];
      `DDMUX_CH_TEST8: pump_bit = 1'b0;
      `DDMUX_CH_BATUV: pump_bit = s[14];
      `DDMUX_CH_BATOV: pump_bit = s[15];
      `DDMUX_CH_V5OT: pump_bit = s[16];
      `DDMUX_CH_V35OT: pump_bit = s[17];
      `DDMUX_CH_VSOT: pump_bit = s[18];
      `DDMUX_CH_V5CL: pump_bit = s[19];
      `DDMUX_CH_V3CL: pump_bit = s[20];
      default: pump_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (diag_channel_i)
      `DDMUX_CH_VSCL: supply_bit = s[21];
      `DDMUX_CH_VSUV: supply_bit = s[22];
      `DDMUX_CH_VSOV: supply_bit = s[23];
      `DDMUX_CH_DUV: supply_bit = s[24];
      `DDMUX_CH_DOV: supply_bit = s[25];
      `DDMUX_CH_TRK: supply_bit = s[26];
      `DDMUX_CH_TRIM: supply_bit = s[27];
      default: supply_bit = 1'b0;
    endcase
  end

  // Groups outside 2..4 are handled elsewhere and read zero here
  wire next_diag = digital_mode & ((sel_timing & timing_bit) | (sel_pump & pump_bit) |
                                   (sel_supply & supply_bit));

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; adds one cycle after the two sync stages
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      diagnostic_output_pin_o <= 1'b0;
      watchdog_time_base_o <= 1'b0;
    end else begin
      diagnostic_output_pin_o <= next_diag;
      watchdog_time_base_o <= wd_phase;
    end
  end
endmodule : ddmux_top

// [ddmux_properties.sv]
// Property checker for the diagnostic digital multiplexer
module ddmux_properties #(
  parameter int WD_HALF_CYCLES = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire ddmux_pkg::ddmux_cfg_type mux_mode_config_i,
  input wire ddmux_pkg::ddmux_group_type diag_group_i,
  input wire ddmux_pkg::ddmux_chan_type diag_channel_i,
  input wire logic reset_stretch_oscillator_i,
  input wire logic host_error_trigger_input_i,
  input wire logic serial_select_tap_i,
  input wire logic serial_out_readback_i,
  input wire logic host_reset_readback_i,
  input wire logic pump_under_flag_n_i,
  input wire logic battery_under_flag_n_i,
  input wire logic sensor_tracking_indication_i,
  input wire logic diagnostic_output_pin_o,
  input wire logic watchdog_time_base_o
);
  import ddmux_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] up;
  logic [15:0] wc;
  logic seen;
  wire logic [8:0] sel = {mux_mode_config_i, diag_group_i, diag_channel_i};
  wire logic rsv = sel[8:7] != 2'h1 || diag_group_i == 3'h0 || diag_group_i > 3'h3
    || sel[6:0] inside {7'h10, 7'h12, 7'h20, 7'h21, 7'h22, 7'h28, 7'h30, 7'h36, [7'h39:7'h3f]};
  ////////////////////////////////////////////////////////////////////////////
  // Sources pass two sync flops, so checks wait until the pipe holds post-reset data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      up <= 2'h0;
      wc <= 16'h0000;
      seen <= 1'b0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      wc <= $changed(watchdog_time_base_o) ? 16'h0001 : wc + 16'h0001;
      if ($changed(watchdog_time_base_o)) seen <= 1'b1;
    end
  end
  property p_route(logic [8:0] code, logic src);
    up == 2'h3 && $past(sel) == code |-> diagnostic_output_pin_o == $past(src, 3);
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  AST_ERR_MIRROR: assert property (p_route(9'h099, host_error_trigger_input_i)) else $error("bad route");
  AST_ERR_COPY: assert property (p_route(9'h09e, host_error_trigger_input_i)) else $error("bad route");
  AST_RST_OSC: assert property (p_route(9'h094, reset_stretch_oscillator_i)) else $error("bad route");
  AST_SEL_TAP: assert property (p_route(9'h09a, serial_select_tap_i)) else $error("bad route");
  AST_SDO_RB: assert property (p_route(9'h09d, serial_out_readback_i)) else $error("bad route");
  AST_RST_RB: assert property (p_route(9'h09f, host_reset_readback_i)) else $error("bad route");
  AST_PUMP_UV: assert property (p_route(9'h0a4, pump_under_flag_n_i)) else $error("bad route");
  AST_BAT_UV: assert property (p_route(9'h0a9, battery_under_flag_n_i)) else $error("bad route");
  AST_TRACK: assert property (p_route(9'h0b7, sensor_tracking_indication_i)) else $error("bad route");
  AST_TEST_CODE: assert property (up == 2'h3 && $past(sel) inside {9'h092, 9'h0a1, 9'h0a2, 9'h0a8}
    |-> !diagnostic_output_pin_o) else $error("test code not low");
  AST_RESERVED: assert property (up == 2'h3 && $past(rsv) |-> !diagnostic_output_pin_o) else $error("not low");
  AST_WD_PERIOD: assert property ($changed(watchdog_time_base_o) && seen |-> wc == WD_HALF_CYCLES)
    else $error("bad half period");
  COV_ERR: cover property (up == 2'h3 && $past(sel) == 9'h099 && diagnostic_output_pin_o);
  COV_RSV: cover property (up == 2'h3 && $past(rsv));
  COV_WD: cover property ($changed(watchdog_time_base_o) && seen);
endmodule : ddmux_properties

bind ddmux_top ddmux_properties #(.WD_HALF_CYCLES(WD_HALF_CYCLES)) u_props (.*);

// [ddmux_mcu_model.sv]
// Host controller model that samples the diagnostic pin and times its rises
module ddmux_mcu_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic [15:0] period_o
);
  logic last;
  logic [15:0] cnt;
  // Period is only meaningful after two rises of the same source
  always @(posedge mclk_i) begin
    last <= pin_i;
    cnt <= (pin_i && !last) ? 16'h0000 : cnt + 16'h0001;
    if (rst_i) period_o <= 16'h0000;
    else if (pin_i && !last) period_o <= cnt + 16'h0001;
  end
endmodule : ddmux_mcu_model

// [test_diag_digital_mux_groups_2_to_4.sv]
// Self-checking bench for the diagnostic digital multiplexer
module test_diag_digital_mux_groups_2_to_4;
  timeunit 1ns;
  timeprecision 1ps;
  import ddmux_pkg::*;
  localparam int W = 4;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  ddmux_cfg_type mode = 2'h1;
  ddmux_group_type grp = 3'h0;
  ddmux_chan_type chan = 4'h0;
  logic [31:0] s = 32'h0000_0000;
  logic out;
  logic wd;
  logic [15:0] per;
  int err_count = 0;
  int check_count = 0;
  // Source bit per channel of groups 001b..011b; -1 must read low, -2 watchdog base
  int tab [3][16] = '{'{-1, 0, -1, -2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 7, 12},
    '{-1, -1, -1, 14, 13, 15, 16, 17, -1, 18, 19, 20, 21, 22, 23, 24},
    '{-1, 25, 26, 27, 28, 29, -1, 30, 31, -1, -1, -1, -1, -1, -1, -1}};
  always #20 mclk_i = ~mclk_i;
  ddmux_top #(.WD_HALF_CYCLES(W)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .mux_mode_config_i(mode),
    .diag_group_i(grp), .diag_channel_i(chan), .system_clock_tap_i(s[0]), .production_test_signal_i(s[1]),
    .reset_stretch_oscillator_i(s[2]), .time_5us_i(s[3]), .time_15us_i(s[4]), .time_40us_i(s[5]),
    .time_2ms_i(s[6]), .host_error_trigger_input_i(s[7]), .serial_select_tap_i(s[8]), .serial_in_tap_i(s[9]),
    .serial_clock_tap_i(s[10]), .serial_out_readback_i(s[11]), .host_reset_readback_i(s[12]),
    .pump_under_flag_n_i(s[13]), .pump_over_flag_i(s[14]), .pump_phase_one_i(s[15]), .pump_phase_two_i(s[16]),
    .pump_headroom_flag_i(s[17]), .battery_under_flag_n_i(s[18]), .battery_over_flag_i(s[19]),
    .vdd5_overtemp_i(s[20]), .vdd35_overtemp_i(s[21]), .sensor_overtemp_i(s[22]), .vdd5_limit_i(s[23]),
    .vdd3_limit_i(s[24]), .sensor_supply_limit_flag_i(s[25]), .sensor_supply_under_n_i(s[26]),
    .sensor_supply_over_flag_i(s[27]), .digital_supply_under_n_i(s[28]), .digital_supply_over_flag_i(s[29]),
    .sensor_tracking_indication_i(s[30]), .monitor_trim_fault_i(s[31]), .diagnostic_output_pin_o(out),
    .watchdog_time_base_o(wd));
  ddmux_mcu_model mcu (.mclk_i(mclk_i), .rst_i(rst_i), .pin_i(out), .period_o(per));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Sources need two sync stages plus the output flop, so four edges is ample
  task automatic apply(input logic [1:0] m, input logic [2:0] g, input logic [3:0] c, input logic [31:0] v);
    @(posedge mclk_i);
    mode <= m;
    grp <= g;
    chan <= c;
    s <= v;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : apply
  // Walking one and walking zero catch both stuck and crossed routes
  task automatic run_table();
    int e;
    logic [31:0] v;
    for (int g = 1; g < 4; g++) begin
      for (int c = 0; c < 16; c++) begin
        e = tab[g-1][c];
        v = (e < 0) ? 32'h0000_0000 : 32'h0000_0001 << e;
        for (int p = 0; p < 2; p++) begin
          if (e != -2) begin
            apply(2'h1, 3'(g), 4'(c), p ? ~v : v);
            if (e < 0) check(out, 16'h0000);
            else check(out, 16'(p == 0));
          end
        end
      end
    end
  endtask : run_table
  task automatic run_refused();
    for (int i = 0; i < 6; i++) begin
      apply(i < 3 ? 2'(i + (i > 0)) : 2'h1, i < 3 ? 3'h1 : 3'(i == 3 ? 0 : i), 4'h9, 32'hffff_ffff);
      check(out, 16'h0000);
    end
  endtask : run_refused
  task automatic run_back_to_back();
    logic [3:0] cs [4] = '{4'h2, 4'he, 4'h0, 4'h9};
    apply(2'h1, 3'h1, 4'h9, 32'h0000_0080);
    check(out, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      if (i < 4) chan <= cs[i];
      @(negedge mclk_i);
      if (i > 0) check(out, 16'(cs[i-1] inside {4'h9, 4'he}));
    end
  endtask : run_back_to_back
  task automatic run_watchdog();
    apply(2'h1, 3'h1, 4'h3, 32'h0000_0000);
    repeat (6 * W) @(posedge mclk_i);
    @(negedge mclk_i);
    check(per, 16'(2 * W));
    check(16'(wd), 16'(out));
  endtask : run_watchdog
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    @(negedge mclk_i);
    check(out, 16'h0000);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    run_table();
    run_refused();
    run_back_to_back();
    run_watchdog();
    complete_run();
  end
  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    complete_run();
  end
endmodule : test_diag_digital_mux_groups_2_to_4
